// >>> rbc_pkg.sv
package rbc_pkg;

    // Register indices; one 16-bit register per index
    localparam logic [15:0] RBC_OFF_PUMP     = 16'h0200;
    localparam logic [15:0] RBC_OFF_CORE     = 16'h0210;
    localparam logic [15:0] RBC_OFF_CORE_PWR = 16'h0212;
    localparam logic [15:0] RBC_OFF_MIC_REG  = 16'h0213;
    localparam logic [15:0] RBC_OFF_BIAS1    = 16'h0218;
    localparam logic [15:0] RBC_OFF_BIAS2    = 16'h0219;
    localparam logic [15:0] RBC_OFF_BIAS3    = 16'h021A;
    localparam logic [15:0] RBC_OFF_ISOLATE  = 16'h02CB;
    localparam logic [15:0] RBC_OFF_PAD      = 16'h0C20;

    // Field positions
    localparam int RBC_BIT_ENA      = 0;
    localparam int RBC_BIT_BYPASS   = 1;
    localparam int RBC_BIT_DISCH    = 2;
    localparam int RBC_BIT_RATE     = 3;
    localparam int RBC_BIT_EXT_CAP  = 15;
    localparam int RBC_VSEL_LSB     = 5;
    localparam int RBC_VSEL_MSB     = 10;
    localparam int RBC_LVL_LSB      = 5;
    localparam int RBC_LVL_MSB      = 8;
    localparam int RBC_BIT_HI_PWR   = 0;
    localparam int RBC_BIT_ISOLATE  = 0;
    localparam int RBC_BIT_PULLDOWN = 15;

    // Implemented bits of each register; the rest read as zero
    localparam logic [15:0] RBC_MASK_PUMP     = 16'h0007;
    localparam logic [15:0] RBC_MASK_CORE     = 16'h07E7;
    localparam logic [15:0] RBC_MASK_CORE_PWR = 16'h0001;
    localparam logic [15:0] RBC_MASK_MIC_REG  = 16'h07E4;
    localparam logic [15:0] RBC_MASK_BIAS     = 16'h81EF;
    localparam logic [15:0] RBC_MASK_ISOLATE  = 16'h0001;
    localparam logic [15:0] RBC_MASK_PAD      = 16'h8000;

    // Reset values
    localparam logic [15:0] RBC_RST_PUMP      = 16'h0006;
    localparam logic [15:0] RBC_RST_CORE      = 16'h00C4;
    localparam logic [15:0] RBC_RST_CORE_PWR  = 16'h0001;
    localparam logic [15:0] RBC_RST_MIC_REG   = 16'h0344;
    localparam logic [15:0] RBC_RST_BIAS      = 16'h01A6;
    localparam logic [15:0] RBC_RST_ISOLATE   = 16'h0000;
    localparam logic [15:0] RBC_RST_PAD       = 16'h8000;

    // Voltage maps in millivolts
    localparam logic [11:0] RBC_CORE_MV_BASE  = 12'h384;
    localparam logic [11:0] RBC_CORE_MV_STEP  = 12'h032;
    localparam logic [11:0] RBC_CORE_MV_HI    = 12'h708;
    localparam logic [11:0] RBC_CORE_MV_TOP   = 12'h4B0;
    localparam logic [5:0]  RBC_CORE_VSEL_MAX = 6'h06;
    localparam logic [11:0] RBC_MIC_MV_BASE   = 12'h6A4;
    localparam logic [11:0] RBC_MIC_MV_STEP   = 12'h032;
    localparam logic [11:0] RBC_MIC_MV_TOP    = 12'hCE4;
    localparam logic [5:0]  RBC_MIC_VSEL_TOP  = 6'h1F;
    localparam logic [11:0] RBC_BIAS_MV_BASE  = 12'h5DC;
    localparam logic [11:0] RBC_BIAS_MV_STEP  = 12'h064;
    localparam logic [11:0] RBC_BIAS_MV_SAT   = 12'hAF0;
    localparam logic [3:0]  RBC_BIAS_LVL_SAT  = 4'hD;

    typedef enum logic
    {
        RBC_AWAKE  = 1'b0,
        RBC_ASLEEP = 1'b1
    } rbc_pwr_t;

    function automatic logic [11:0] rbc_step_mv(input logic [11:0] base,
                                                input logic [11:0] step,
                                                input logic [5:0]  code);
        rbc_step_mv = 12'(base + step * {6'h00, code});
    endfunction

endpackage

// >>> rbc_bias_channel.sv
`timescale 1ns/100ps
module rbc_bias_channel
    import rbc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] ctrl_i,
    output logic             enable_o,
    output logic             bypass_path_o,
    output logic             regulate_o,
    output logic [11:0]      level_mv_o,
    output logic             ramp_slow_o,
    output logic             ext_cap_o,
    output logic             discharge_o
);

    wire       en_bit     = ctrl_i[RBC_BIT_ENA];
    wire       bypass_bit = ctrl_i[RBC_BIT_BYPASS];
    wire [3:0] lvl_code   = ctrl_i[RBC_LVL_MSB:RBC_LVL_LSB];
    wire [11:0] level_next = (lvl_code >= RBC_BIAS_LVL_SAT) ? RBC_BIAS_MV_SAT :
                             rbc_step_mv(RBC_BIAS_MV_BASE, RBC_BIAS_MV_STEP, {2'b00, lvl_code});

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            enable_o      <= 1'b0;
            bypass_path_o <= 1'b0;
            regulate_o    <= 1'b0;
            level_mv_o    <= RBC_BIAS_MV_SAT;
            ramp_slow_o   <= 1'b0;
            ext_cap_o     <= 1'b0;
            discharge_o   <= 1'b1;
        end
        else
        begin
            enable_o      <= en_bit;
            bypass_path_o <= en_bit & bypass_bit;
            regulate_o    <= en_bit & ~bypass_bit;
            level_mv_o    <= level_next;
            ramp_slow_o   <= bypass_bit & ctrl_i[RBC_BIT_RATE];
            ext_cap_o     <= ~bypass_bit & ctrl_i[RBC_BIT_EXT_CAP];
            discharge_o   <= ~en_bit & ctrl_i[RBC_BIT_DISCH];
        end
    end

    chk_bias_saturate: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ctrl_i[RBC_LVL_MSB:RBC_LVL_LSB] >= 4'hD) |=> (level_mv_o == 12'hAF0))
        else $error("bias level not saturated at top codes");

    chk_bias_discharge: assert property (@(posedge mclk_i) disable iff (rst_i)
        discharge_o |-> !enable_o && $past(ctrl_i[RBC_BIT_DISCH]))
        else $error("bias discharge while enabled or not requested");

endmodule // rbc_bias_channel

// >>> rbc_regulator_bias_control.sv
`timescale 1ns/100ps
// Operation
// - Core regulator on when enable pin high or software enable bit set.
// - Core regulator bypass applies only while regulator is enabled.
// - Disabled core regulator output discharged when discharge bit set, else floats.
// - High-power bit forces core output to 1.8V over voltage select.
// - Core voltage select bits 10:5, reset 06h, 0.9V to 1.2V.
// - Internal core supply: regulator off means sleep; other supplies stay.
// - Enable pin pull-down on by default, switchable off by register.
// - Clearing software enable with pin low disables regulator; sleeps only with internal core supply.
// - Pump register bit 0 enables mic charge pump and mic regulator.
// - Pump bit 1 bypass, reset 1, needs pump enable set too.
// - Pump bit 2, reset 1, discharges pump output while disabled.
// - Mic regulator voltage bits 10:5, reset 1Ah, 1.7V plus 50mV, code 1Fh and above give 3.3V.
// - Mic regulator bit 2, reset 1, discharges mic supply when off.
// - Bias register bit 0 enables that bias output, reset 0.
// - Bias bit 1 selects regulator or bypass mode, reset bypass.
// - Bias bits 8:5 set level, 1.5V plus 0.1V, saturating 2.8V.
// - Bias bit 3 selects fast or pop-free ramp in bypass mode.
// - Bias bit 15 flags external capacitor in regulator mode.
// - Bias bit 2, reset 1, discharges bias output while disabled.
// - Isolation bit clears automatically on wake-up from sleep.
module rbc_regulator_bias_control
    import rbc_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          rst_i,
    input  wire logic          core_reg_enable_pin_i,
    input  wire logic          core_supply_external_i,
    input  wire logic          core_supply_present_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    input  wire logic [15:0]   reg_addr_i,
    input  wire logic [15:0]   reg_wdata_i,
    output logic [15:0]        reg_rdata_o,
    output logic               core_reg_on_o,
    output logic               core_reg_bypass_o,
    output logic               core_reg_discharge_o,
    output logic               core_reg_high_power_o,
    output logic [11:0]        core_reg_voltage_mv_o,
    output logic               core_vsel_reserved_o,
    output logic               sleep_o,
    output logic               always_on_isolate_o,
    output logic               enable_pin_pulldown_o,
    output logic               mic_pump_enable_o,
    output logic               mic_pump_bypass_o,
    output logic               mic_pump_discharge_o,
    output logic               mic_reg_discharge_o,
    output logic [11:0]        mic_reg_voltage_mv_o,
    output logic               mic_vsel_reserved_o,
    output logic [2:0]         bias_enable_o,
    output logic [2:0]         bias_bypass_path_o,
    output logic [2:0]         bias_regulate_o,
    output logic [2:0][11:0]   bias_level_mv_o,
    output logic [2:0]         bias_ramp_slow_o,
    output logic [2:0]         bias_ext_cap_o,
    output logic [2:0]         bias_discharge_o
);

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
        hit = (addr == off);
    endfunction

    // Pin inputs cross from the host's domain
    logic        pin_meta_reg;
    logic        pin_sync_reg;
    logic        ext_meta_reg;
    logic        ext_sync_reg;
    logic        present_meta_reg;
    logic        present_sync_reg;

    logic [15:0] pump_reg;
    logic [15:0] core_reg;
    logic [15:0] core_pwr_reg;
    logic [15:0] mic_reg;
    logic [15:0] bias_reg [3];
    logic [15:0] isolate_reg;
    logic [15:0] pad_reg;
    rbc_pwr_t    pwr_state_reg;
    rbc_pwr_t    pwr_state_next;

    wire wr_pump     = reg_wr_i && hit(reg_addr_i, RBC_OFF_PUMP);
    wire wr_core     = reg_wr_i && hit(reg_addr_i, RBC_OFF_CORE);
    wire wr_core_pwr = reg_wr_i && hit(reg_addr_i, RBC_OFF_CORE_PWR);
    wire wr_mic      = reg_wr_i && hit(reg_addr_i, RBC_OFF_MIC_REG);
    wire wr_isolate  = reg_wr_i && hit(reg_addr_i, RBC_OFF_ISOLATE);
    wire wr_pad      = reg_wr_i && hit(reg_addr_i, RBC_OFF_PAD);
    wire [2:0] wr_bias = {reg_wr_i && hit(reg_addr_i, RBC_OFF_BIAS3),
                          reg_wr_i && hit(reg_addr_i, RBC_OFF_BIAS2),
                          reg_wr_i && hit(reg_addr_i, RBC_OFF_BIAS1)};

    wire       core_sw_en  = core_reg[RBC_BIT_ENA];
    wire       core_hi_pwr = core_pwr_reg[RBC_BIT_HI_PWR];
    wire [5:0] core_vsel   = core_reg[RBC_VSEL_MSB:RBC_VSEL_LSB];
    wire [5:0] mic_vsel    = mic_reg[RBC_VSEL_MSB:RBC_VSEL_LSB];
    wire       pump_en     = pump_reg[RBC_BIT_ENA];
    wire       isolate_bit = isolate_reg[RBC_BIT_ISOLATE];

    wire core_on_next = pin_sync_reg | core_sw_en;
    wire core_bypass_next = core_on_next & core_reg[RBC_BIT_BYPASS];
    wire core_disch_next  = ~core_on_next & core_reg[RBC_BIT_DISCH];

    // reserved codes keep the top valid level so the rail never goes out of range
    wire core_vsel_bad = core_vsel > RBC_CORE_VSEL_MAX;
    wire [11:0] core_vsel_mv = core_vsel_bad ? RBC_CORE_MV_TOP :
                               rbc_step_mv(RBC_CORE_MV_BASE, RBC_CORE_MV_STEP, core_vsel);
    wire [11:0] core_mv_next = core_hi_pwr ? RBC_CORE_MV_HI : core_vsel_mv;

    wire mic_vsel_bad = mic_vsel > RBC_MIC_VSEL_TOP;
    wire [11:0] mic_mv_next = (mic_vsel == RBC_MIC_VSEL_TOP || mic_vsel_bad) ? RBC_MIC_MV_TOP :
                              rbc_step_mv(RBC_MIC_MV_BASE, RBC_MIC_MV_STEP, mic_vsel);

    // internal supply: regulator off removes the core supply
    // external supply: host isolates first, then pulls the supply
    wire sleep_cond = ext_sync_reg ? (isolate_bit & ~present_sync_reg) : ~core_on_next;
    assign pwr_state_next = sleep_cond ? RBC_ASLEEP : RBC_AWAKE;
    wire wake_event = (pwr_state_reg == RBC_ASLEEP) && (pwr_state_next == RBC_AWAKE);

    wire [15:0] rdata_next =
        hit(reg_addr_i, RBC_OFF_PUMP)     ? pump_reg     :
        hit(reg_addr_i, RBC_OFF_CORE)     ? core_reg     :
        hit(reg_addr_i, RBC_OFF_CORE_PWR) ? core_pwr_reg :
        hit(reg_addr_i, RBC_OFF_MIC_REG)  ? mic_reg      :
        hit(reg_addr_i, RBC_OFF_BIAS1)    ? bias_reg[0]  :
        hit(reg_addr_i, RBC_OFF_BIAS2)    ? bias_reg[1]  :
        hit(reg_addr_i, RBC_OFF_BIAS3)    ? bias_reg[2]  :
        hit(reg_addr_i, RBC_OFF_ISOLATE)  ? isolate_reg  :
        hit(reg_addr_i, RBC_OFF_PAD)      ? pad_reg      : 16'h0000;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pin_meta_reg     <= 1'b0;
            pin_sync_reg     <= 1'b0;
            ext_meta_reg     <= 1'b0;
            ext_sync_reg     <= 1'b0;
            present_meta_reg <= 1'b0;
            present_sync_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg     <= core_reg_enable_pin_i;
            pin_sync_reg     <= pin_meta_reg;
            ext_meta_reg     <= core_supply_external_i;
            ext_sync_reg     <= ext_meta_reg;
            present_meta_reg <= core_supply_present_i;
            present_sync_reg <= present_meta_reg;
        end
    end

    // software write may clear the enable bit at any time
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pump_reg     <= RBC_RST_PUMP;
            core_reg     <= RBC_RST_CORE;
            core_pwr_reg <= RBC_RST_CORE_PWR;
            mic_reg      <= RBC_RST_MIC_REG;
            pad_reg      <= RBC_RST_PAD;
        end
        else
        begin
            if (wr_pump)
                pump_reg <= reg_wdata_i & RBC_MASK_PUMP;
            if (wr_core)
                core_reg <= reg_wdata_i & RBC_MASK_CORE;
            if (wr_core_pwr)
                core_pwr_reg <= reg_wdata_i & RBC_MASK_CORE_PWR;
            if (wr_mic)
                mic_reg <= reg_wdata_i & RBC_MASK_MIC_REG;
            if (wr_pad)
                pad_reg <= reg_wdata_i & RBC_MASK_PAD;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (rst_i)
                bias_reg[i] <= RBC_RST_BIAS;
            else if (wr_bias[i])
                bias_reg[i] <= reg_wdata_i & RBC_MASK_BIAS;
        end
    end

    // wake-up clears isolation; wins over a write in the same cycle
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            isolate_reg <= RBC_RST_ISOLATE;
        else if (wake_event)
            isolate_reg <= RBC_RST_ISOLATE;
        else if (wr_isolate)
            isolate_reg <= reg_wdata_i & RBC_MASK_ISOLATE;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pwr_state_reg         <= RBC_ASLEEP;
            reg_rdata_o           <= 16'h0000;
            core_reg_on_o         <= 1'b0;
            core_reg_bypass_o     <= 1'b0;
            core_reg_discharge_o  <= 1'b1;
            core_reg_high_power_o <= 1'b1;
            core_reg_voltage_mv_o <= RBC_CORE_MV_HI;
            core_vsel_reserved_o  <= 1'b0;
            sleep_o               <= 1'b1;
        end
        else
        begin
            pwr_state_pipe: pwr_state_reg <= pwr_state_next;
            if (reg_rd_i)
                reg_rdata_o <= rdata_next;
            core_reg_on_o         <= core_on_next;
            core_reg_bypass_o     <= core_bypass_next;
            core_reg_discharge_o  <= core_disch_next;
            core_reg_high_power_o <= core_hi_pwr;
            core_reg_voltage_mv_o <= core_mv_next;
            core_vsel_reserved_o  <= core_vsel_bad;
            sleep_o               <= pwr_state_next == RBC_ASLEEP;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            always_on_isolate_o   <= 1'b0;
            enable_pin_pulldown_o <= 1'b1;
            mic_pump_enable_o     <= 1'b0;
            mic_pump_bypass_o     <= 1'b0;
            mic_pump_discharge_o  <= 1'b1;
            mic_reg_discharge_o   <= 1'b1;
            mic_reg_voltage_mv_o  <= 12'hBB8;
            mic_vsel_reserved_o   <= 1'b0;
        end
        else
        begin
            always_on_isolate_o   <= isolate_bit;
            enable_pin_pulldown_o <= pad_reg[RBC_BIT_PULLDOWN];
            mic_pump_enable_o     <= pump_en;
            mic_pump_bypass_o     <= pump_en & pump_reg[RBC_BIT_BYPASS];
            mic_pump_discharge_o  <= ~pump_en & pump_reg[RBC_BIT_DISCH];
            mic_reg_discharge_o   <= ~pump_en & mic_reg[RBC_BIT_DISCH];
            mic_reg_voltage_mv_o  <= mic_mv_next;
            mic_vsel_reserved_o   <= mic_vsel_bad;
        end
    end

    for (genvar g = 0; g < 3; g++)
    begin : g_bias
        rbc_bias_channel u_bias (
            .mclk_i        (mclk_i),
            .rst_i         (rst_i),
            .ctrl_i        (bias_reg[g]),
            .enable_o      (bias_enable_o[g]),
            .bypass_path_o (bias_bypass_path_o[g]),
            .regulate_o    (bias_regulate_o[g]),
            .level_mv_o    (bias_level_mv_o[g]),
            .ramp_slow_o   (bias_ramp_slow_o[g]),
            .ext_cap_o     (bias_ext_cap_o[g]),
            .discharge_o   (bias_discharge_o[g])
        );
    end

    sequence sw_off_req;
        reg_wr_i && reg_addr_i == RBC_OFF_CORE && !reg_wdata_i[RBC_BIT_ENA]
            && !pin_sync_reg ##1 !pin_sync_reg && !ext_sync_reg;
    endsequence

    sequence wake_seen;
        sleep_o ##1 !sleep_o;
    endsequence

    chk_pin_enables_core: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(core_reg_enable_pin_i) |-> ##3 core_reg_on_o)
        else $error("enable pin did not turn the core regulator on");

    chk_core_on_or: assert property (@(posedge mclk_i) disable iff (rst_i)
        !core_reg_on_o |-> !$past(pin_sync_reg) && !$past(core_sw_en))
        else $error("core regulator off while an enable is present");

    chk_bypass_gated: assert property (@(posedge mclk_i) disable iff (rst_i)
        core_reg_bypass_o |-> core_reg_on_o)
        else $error("core bypass applied while regulator off");

    chk_core_discharge: assert property (@(posedge mclk_i) disable iff (rst_i)
        core_reg_discharge_o == (!core_reg_on_o && $past(core_reg[RBC_BIT_DISCH])))
        else $error("core discharge wrong for enable state");

    chk_high_power: assert property (@(posedge mclk_i) disable iff (rst_i)
        $past(core_hi_pwr) |-> core_reg_voltage_mv_o == 12'h708)
        else $error("high power did not force 1.8V");

    chk_vsel_map: assert property (@(posedge mclk_i) disable iff (rst_i)
        !$past(core_hi_pwr) && $past(core_vsel) == 6'h01 |-> core_reg_voltage_mv_o == 12'h3B6)
        else $error("core voltage select map wrong");

    chk_sleep_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
        !$past(ext_sync_reg) && $fell(core_reg_on_o) |-> sleep_o)
        else $error("no sleep after internal regulator turned off");

    chk_sw_disable: assert property (@(posedge mclk_i) disable iff (rst_i)
        sw_off_req |=> !core_reg_on_o && sleep_o)
        else $error("clearing software enable did not disable regulator");

    chk_pump_bypass: assert property (@(posedge mclk_i) disable iff (rst_i)
        mic_pump_bypass_o |-> mic_pump_enable_o)
        else $error("pump bypass without pump enable");

    chk_mic_top_code: assert property (@(posedge mclk_i) disable iff (rst_i)
        $past(mic_vsel) == 6'h1F |-> mic_reg_voltage_mv_o == 12'hCE4)
        else $error("mic top code not 3.3V");

    chk_wake_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
        wake_seen |=> !always_on_isolate_o)
        else $error("isolation not cleared on wake-up");

    chk_readback: assert property (@(posedge mclk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == RBC_OFF_BIAS2 |=> reg_rdata_o == $past(bias_reg[1]))
        else $error("readback of bias two wrong");

endmodule // rbc_regulator_bias_control

// >>> rbc_host_model.sv
`timescale 1ns/100ps
module rbc_host_model
    import rbc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic [15:0] rdata_i,
    output logic             pin_o,
    output logic             ext_o,
    output logic             present_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic [15:0]      addr_o,
    output logic [15:0]      wdata_o
);
    initial
    begin
        {pin_o, ext_o, wr_o, rd_o} = 4'h0;
        present_o = 1'b1;
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
    end
    // Called at a falling edge; one-cycle strobe
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge mclk_i);
        wr_o = 1'b0;
        // Released data bus never shows stale value
        wdata_o = ~d;
        // Idle edge so back-to-back calls never retoggle the strobe
        @(negedge mclk_i);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge mclk_i);
        rd_o = 1'b0;
        d = rdata_i;
        @(negedge mclk_i);
    endtask
    task automatic pin(input logic v);
        pin_o = v;
    endtask
    task automatic supply(input logic e, input logic p);
        ext_o = e;
        present_o = p;
    endtask
    task automatic sleep_ext();
        wr(RBC_OFF_ISOLATE, 16'h0001);
        present_o = 1'b0;
    endtask
endmodule // rbc_host_model

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import rbc_pkg::*;
    logic mclk_i = 1'b0, rst_i = 1'b1, pin, ext, pres, wr, rd, on, bp, dis, hp, slp, iso, pd;
    logic pe, pb, pdis, mdis, cvr, mvr;
    logic [15:0] addr, wdata, rdata, d, c, r = 16'h003A;
    logic [15:0] bv [3];
    logic [11:0] cmv, mmv;
    logic [2:0] ben, bbp, brg, bsl, bcp, bds;
    logic [2:0][11:0] bmv;
    int num_errors = 0, check_count = 0;
    logic [15:0] ra [10] = '{RBC_OFF_PUMP, RBC_OFF_CORE, RBC_OFF_CORE_PWR, RBC_OFF_MIC_REG,
        RBC_OFF_BIAS1, RBC_OFF_BIAS2, RBC_OFF_BIAS3, RBC_OFF_ISOLATE, RBC_OFF_PAD, 16'h0201};
    logic [15:0] rv [10] = '{16'h0006, 16'h00C4, 16'h0001, 16'h0344, 16'h01A6, 16'h01A6,
        16'h01A6, 16'h0000, 16'h8000, 16'h0000};
    always #2.5 mclk_i = ~mclk_i;
    rbc_host_model host (.mclk_i(mclk_i), .rdata_i(rdata), .pin_o(pin), .ext_o(ext),
        .present_o(pres), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    rbc_regulator_bias_control dut (.mclk_i(mclk_i), .rst_i(rst_i), .core_reg_enable_pin_i(pin),
        .core_supply_external_i(ext), .core_supply_present_i(pres), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .core_reg_on_o(on), .core_reg_bypass_o(bp), .core_reg_discharge_o(dis),
        .core_reg_high_power_o(hp), .core_reg_voltage_mv_o(cmv), .core_vsel_reserved_o(cvr),
        .sleep_o(slp), .always_on_isolate_o(iso), .enable_pin_pulldown_o(pd),
        .mic_pump_enable_o(pe), .mic_pump_bypass_o(pb), .mic_pump_discharge_o(pdis),
        .mic_reg_discharge_o(mdis), .mic_reg_voltage_mv_o(mmv), .mic_vsel_reserved_o(mvr),
        .bias_enable_o(ben), .bias_bypass_path_o(bbp), .bias_regulate_o(brg),
        .bias_level_mv_o(bmv), .bias_ramp_slow_o(bsl), .bias_ext_cap_o(bcp),
        .bias_discharge_o(bds));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [5:0] bias_bits(input logic [15:0] v);
        return {v[0], v[0] & v[1], v[0] & ~v[1], v[1] & v[3], ~v[1] & v[15], ~v[0] & v[2]};
    endfunction
    function automatic logic [15:0] bias_mv(input logic [3:0] l);
        return (l >= 4'hD) ? 16'd2800 : 16'(1500 + 100 * l);
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_r(input logic [15:0] a, input logic [15:0] exp);
        host.rd(a, d);
        cmp(d, exp);
    endtask
    task automatic chk_o(input logic [15:0] got, input logic [15:0] exp);
        cmp(got, exp);
    endtask
    task automatic w2(input logic [15:0] a, input logic [15:0] v);
        host.wr(a, v);
        repeat (2) @(negedge mclk_i);
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (4) @(negedge mclk_i);
        rst_i = 1'b0;
        foreach (ra[i]) chk_r(ra[i], rv[i]);
        chk_o({slp, dis, hp, pd, cmv}, 16'hF708);
        host.pin(1'b1);
        repeat (4) @(negedge mclk_i);
        chk_o({on, slp}, 16'h0002);
        w2(RBC_OFF_CORE, 16'h00C7);
        host.pin(1'b0);
        repeat (4) @(negedge mclk_i);
        chk_o({on, bp, dis, slp}, 16'h000C);
        w2(RBC_OFF_CORE, 16'h00C6);
        chk_o({on, bp, dis, slp}, 16'h0003);
        w2(RBC_OFF_CORE, 16'h00C2);
        chk_o({on, dis}, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            r = lfsr(r);
            c = r;
            host.wr(RBC_OFF_CORE, {5'h00, 6'(c % 7), 5'h01});
            host.wr(RBC_OFF_CORE_PWR, {15'h0000, c[15]});
            host.wr(RBC_OFF_MIC_REG, {6'h00, c[9:5], 5'h04});
            host.wr(RBC_OFF_PUMP, {13'h0000, c[12:10]});
            for (int k = 0; k < 3; k++)
            begin
                r = lfsr(r);
                bv[k] = r;
                host.wr(RBC_OFF_BIAS1 + 16'(k), r);
            end
            repeat (2) @(negedge mclk_i);
            chk_o(cmv, c[15] ? 16'd1800 : 16'(900 + 50 * (c % 7)));
            chk_o(mmv, (c[9:5] == 5'h1F) ? 16'd3300 : 16'(1700 + 50 * c[9:5]));
            chk_o({pe, pb, pdis, mdis}, {c[10], c[10] & c[11], ~c[10] & c[12], ~c[10]});
            chk_o({cvr, mvr}, 16'h0000);
            for (int k = 0; k < 3; k++)
            begin
                chk_o({ben[k], bbp[k], brg[k], bsl[k], bcp[k], bds[k]}, bias_bits(bv[k]));
                chk_o(bmv[k], bias_mv(bv[k][8:5]));
                chk_r(RBC_OFF_BIAS1 + 16'(k), bv[k] & 16'h81EF);
            end
        end
        // Reserved select codes on both regulators
        w2(RBC_OFF_CORE_PWR, 16'h0000);
        host.wr(RBC_OFF_CORE, 16'h00E1);
        w2(RBC_OFF_MIC_REG, 16'h0404);
        chk_o({cvr, mvr, cmv}, {2'b11, RBC_CORE_MV_TOP});
        chk_o(mmv, RBC_MIC_MV_TOP);
        host.supply(1'b1, 1'b1);
        repeat (3) @(negedge mclk_i);
        host.sleep_ext();
        repeat (4) @(negedge mclk_i);
        chk_o({slp, iso}, 16'h0003);
        host.supply(1'b1, 1'b1);
        repeat (4) @(negedge mclk_i);
        chk_o({slp, iso}, 16'h0000);
        w2(RBC_OFF_PAD, 16'h0000);
        chk_o(pd, 16'h0000);
        report_and_stop();
    end
endmodule // tb_top
